// ### timer2_control_logic_tb.sv
// self-checking bench for the timer-two control logic
`timescale 1ns/1ps
`default_nettype none
module timer2_control_logic_tb;
	import tmr2_pkg::*;
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] x;
		logic e;
	} tmr2_row_t;
	logic sys_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, irq, countInputPin, triggerPin, e;
	tmr2_baud_t baudOut;
	int n_fail = 0, tests_run = 0, rxTicks = 0, txTicks = 0;
	tmr2_row_t rows [4] = '{'{12'hd0, 32'h1234, 32'h1234, 1'b0},
		'{12'hd8, 32'h3, 32'h3, 1'b0}, '{12'he0, 32'h5a, 32'h0, 1'b1},
		'{12'hc8, 32'h0a, 32'h0a, 1'b0}};
	always #10 sys_clk = ~sys_clk;
	tmr2_ctrl uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .countInputPin(countInputPin), .triggerPin(triggerPin),
		.baudOut(baudOut), .irq(irq));
	tmr2_pin_model pins (.sys_clk(sys_clk), .countInputPin(countInputPin),
		.triggerPin(triggerPin));
	// receive ticks are single-cycle pulses, so count them as they pass
	always @(posedge sys_clk) if (baudOut.receiveBaudTick === 1'b1) rxTicks <= rxTicks + 1;
	always @(posedge sys_clk) if (baudOut.transmitBaudTick === 1'b1) txTicks <= txTicks + 1;
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		tests_run++;
		if (g !== x) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), x, r);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// a hang costs a mismatch; the whole run needs well under this
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		stop_test();
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(12'hc8, 32'h0);
		rd(12'hcc, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			chk("pslverr", rows[i].e, e);
			rd(rows[i].a, rows[i].x);
		end
		$display("test registers done");
		wr(12'hcc, 32'h0);
		wr(12'hc8, 32'h06);
		pins.pulse(1'b0, 5);
		wr(12'hc8, 32'h02);
		pins.pulse(1'b0, 3);
		rd(12'hcc, 32'h5);
		wr(12'hcc, 32'hfffe);
		wr(12'hc8, 32'h06);
		pins.pulse(1'b0, 3);
		rd(12'hc8, 32'h86);
		rd(12'hcc, 32'h1235);
		chk("irq", 1'b1, irq);
		repeat (20) @(posedge sys_clk);
		rd(12'hc8, 32'h86);
		wr(12'hd4, 32'h1);
		@(posedge sys_clk);
		chk("irq", 1'b0, irq);
		wr(12'hc8, 32'h0);
		rd(12'hc8, 32'h0);
		$display("test counter done");
		wr(12'hd8, 32'h1);
		wr(12'hcc, 32'h42);
		wr(12'hc8, 32'h09);
		pins.pulse(1'b1, 1);
		rd(12'hd0, 32'h42);
		rd(12'hc8, 32'h49);
		chk("irq", 1'b0, irq);
		wr(12'hc8, 32'h01);
		wr(12'hcc, 32'h77);
		pins.pulse(1'b1, 1);
		rd(12'hd0, 32'h42);
		$display("test trigger done");
		wr(12'hcc, 32'hffff);
		wr(12'hc8, 32'h26);
		pins.pulse(1'b0, 1);
		rd(12'hc8, 32'h26);
		chk("rx ticks", 32'h1, rxTicks);
		chk("tx ticks", 32'h0, txTicks);
		wr(12'hcc, 32'h0);
		wr(12'hc8, 32'h04);
		repeat (120) @(posedge sys_clk);
		wr(12'hc8, 32'h0);
		apb(1'b0, 12'hcc, 32'h0);
		chk("tick count", 1'b1, r >= 32'h9 && r <= 32'hb);
		$display("test baud and timer done");
		stop_test();
	end
endmodule
`default_nettype wire

// ### tmr2_cfg.svh
// constants and the plain-words list for the timer-two control logic
// How it works
// - overflow sets the overflow flag only when both serial clock selects are zero
// - hardware never clears the overflow flag; software writes zero
// - trigger-caused capture or reload sets the external event flag; software clears it
// - select bit zero counts the internal clock tick
// - select bit one counts falling edges of the count input pin
// - control register resets to zero; single bits can be set, cleared, tested
// - counting happens only while run is one; two bytes cascade to 16 bits
// - serial selects and capture select together choose the operating mode
// - auto-reload overflow from ffff loads the reload pair into the count
`ifndef TMR2_CFG_SVH
`define TMR2_CFG_SVH
`define TMR2_ADDR_CTRL 12'hc8
`define TMR2_ADDR_COUNT 12'hcc
`define TMR2_ADDR_RELOAD 12'hd0
`define TMR2_ADDR_IRQ_STAT 12'hd4
`define TMR2_ADDR_IRQ_MASK 12'hd8
`define TMR2_CTRL_RESET 8'h00
`define TMR2_BIT_OVF 7
`define TMR2_BIT_EXT 6
`define TMR2_BIT_RCLK 5
`define TMR2_BIT_TRANSMIT_CLOCK_SELECT 4
`define TMR2_BIT_EXEN 3
`define TMR2_BIT_RUN 2
`define TMR2_BIT_CT 1
`define TMR2_BIT_CP 0
`define TMR2_COUNT_MAX 16'hffff
`define TMR2_PRESCALE 4'hb
`define TMR2_ERR_SLVERR 1'b1
`endif

// ### tmr2_ctrl.sv
// timer-two counter, control register, flags and apb slave
`timescale 1ns/1ps
`default_nettype none
`include "tmr2_cfg.svh"
module tmr2_ctrl (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic countInputPin,
	input wire logic triggerPin,
	output tmr2_pkg::tmr2_baud_t baudOut,
	output logic irq
);
	import tmr2_pkg::*;

	tmr2_ctrl_t ctrl_q;
	logic [15:0] count_q;
	logic [15:0] reload_q;
	logic [1:0] irqStat_q;
	logic [1:0] irqMask_q;
	logic [2:0] cntSync_q;
	logic [2:0] trgSync_q;
	logic [3:0] pre_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic irq_q;
	tmr2_baud_t baud_q;

	// pin synchronisers: bit 0 is read only by bit 1
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cntSync_q <= 3'h0;
			trgSync_q <= 3'h0;
		end else begin
			cntSync_q <= {cntSync_q[1:0], countInputPin};
			trgSync_q <= {trgSync_q[1:0], triggerPin};
		end
	end

	// falling edges seen on the synchronised pins
	wire cntFall = cntSync_q[2] & ~cntSync_q[1];
	wire trgFall = trgSync_q[2] & ~trgSync_q[1];

	// internal tick divides by twelve, like a machine cycle
	wire intTick = (pre_q == `TMR2_PRESCALE);
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			pre_q <= 4'h0;
		else
			pre_q <= intTick ? 4'h0 : pre_q + 4'h1;
	end

	// mode decode
	wire serialUse = ctrl_q.receiveClockSelect | ctrl_q.transmitClockSelect;
	tmr2_mode_t mode;
	assign mode = serialUse ? TMR2_BAUD :
		(ctrl_q.captureReloadSelect ? TMR2_CAPTURE : TMR2_RELOAD);
	wire srcTick = ctrl_q.counterTimerSelect ? cntFall : intTick;
	wire step = ctrl_q.runControl & srcTick;
	wire wrap = step & (count_q == `TMR2_COUNT_MAX);
	// trigger acts only when enabled and not in baud mode
	wire trigAct = ctrl_q.externalTriggerEnable & trgFall & (mode != TMR2_BAUD);
	wire doCapture = trigAct & (mode == TMR2_CAPTURE);
	wire doReload = (wrap & (mode != TMR2_CAPTURE)) | (trigAct & (mode == TMR2_RELOAD));
	wire ovfSet = wrap & ~serialUse;
	wire extSet = trigAct;

	// apb decode: writes land only on the completing edge, so a held
	// access phase never applies the same write twice
	wire access = psel & penable;
	wire wrEn = access & pwrite & pready_q;
	wire hitCtrl = (paddr == `TMR2_ADDR_CTRL);
	wire hitCount = (paddr == `TMR2_ADDR_COUNT);
	wire hitReload = (paddr == `TMR2_ADDR_RELOAD);
	wire hitStat = (paddr == `TMR2_ADDR_IRQ_STAT);
	wire hitMask = (paddr == `TMR2_ADDR_IRQ_MASK);
	wire hitAny = hitCtrl | hitCount | hitReload | hitStat | hitMask;
	wire [31:0] rdMux = hitCtrl ? {24'h000000, ctrl_q} :
		hitCount ? {16'h0000, count_q} :
		hitReload ? {16'h0000, reload_q} :
		hitStat ? {30'h0, irqStat_q} :
		hitMask ? {30'h0, irqMask_q} : 32'h00000000;

	// control register next value; hardware set beats software clear
	tmr2_ctrl_t ctrlWr;
	assign ctrlWr = (wrEn & hitCtrl) ? tmr2_ctrl_t'(pwdata[7:0]) : ctrl_q;
	tmr2_ctrl_t ctrl_d;
	always_comb begin
		ctrl_d = ctrlWr;
		ctrl_d.overflowFlag = ctrlWr.overflowFlag | ovfSet;
		ctrl_d.externalEventFlag = ctrlWr.externalEventFlag | extSet;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			ctrl_q <= tmr2_ctrl_t'(`TMR2_CTRL_RESET);
		else
			ctrl_q <= ctrl_d;
	end

	// counter: reload beats increment, software write beats both
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			count_q <= 16'h0000;
		else if (wrEn & hitCount)
			count_q <= pwdata[15:0];
		else if (doReload)
			count_q <= reload_q;
		else if (step)
			count_q <= count_q + 16'h0001;
	end

	// reload/capture pair
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			reload_q <= 16'h0000;
		else if (doCapture)
			reload_q <= count_q;
		else if (wrEn & hitReload)
			reload_q <= pwdata[15:0];
	end

	// interrupt status: write one to clear, new event wins
	wire [1:0] evt = {extSet, ovfSet};
	wire [1:0] statClr = (wrEn & hitStat) ? pwdata[1:0] : 2'h0;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			irqStat_q <= 2'h0;
			irqMask_q <= 2'h0;
			irq_q <= 1'b0;
		end else begin
			irqStat_q <= (irqStat_q & ~statClr) | evt;
			if (wrEn & hitMask)
				irqMask_q <= pwdata[1:0];
			irq_q <= |(((irqStat_q & ~statClr) | evt) & irqMask_q);
		end
	end

	// baud ticks: overflow routed per serial select
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			baud_q <= '0;
		else
			baud_q <= '{receiveBaudTick: wrap & ctrl_q.receiveClockSelect,
				transmitBaudTick: wrap & ctrl_q.transmitClockSelect};
	end

	// apb answer registered; pready rises one cycle into access
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= access & ~pready_q;
			prdata_q <= rdMux;
			pslverr_q <= access & ~pready_q & ~hitAny & `TMR2_ERR_SLVERR;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;
	assign baudOut = baud_q;

	// assertions
	a_ovf_gated: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(wrap & serialUse & ~(wrEn & hitCtrl) & ~ctrl_q.overflowFlag) |=> !ctrl_q.overflowFlag)
		else $error("overflow flag set in baud mode");
	a_ovf_sets: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(wrap & ~serialUse) |=> ctrl_q.overflowFlag)
		else $error("overflow flag missed");
	a_ovf_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(ctrl_q.overflowFlag & ~(wrEn & hitCtrl)) |=> ctrl_q.overflowFlag)
		else $error("overflow flag cleared by hardware");
	a_ext_sets: assert property (@(posedge sys_clk) disable iff (sys_rst)
		trigAct |=> ctrl_q.externalEventFlag)
		else $error("external flag missed");
	a_trig_ignored: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(!ctrl_q.externalTriggerEnable & !step & !(wrEn & (hitCount | hitReload)))
		|=> $stable(reload_q))
		else $error("capture while trigger disabled");
	a_run_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(!ctrl_q.runControl & !trigAct & !(wrEn & hitCount)) |=> $stable(count_q))
		else $error("count moved while stopped");
	a_reload_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(wrap & mode == TMR2_RELOAD & !(wrEn & hitCount)) |=> count_q == $past(reload_q))
		else $error("reload not loaded");
	a_ctr_edge: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(ctrl_q.runControl & ctrl_q.counterTimerSelect & !cntFall & !trigAct
		& !(wrEn & hitCount)) |=> $stable(count_q))
		else $error("counter moved without pin edge");
	a_baud_route: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(wrap & ctrl_q.transmitClockSelect) |=> baudOut.transmitBaudTick)
		else $error("transmit baud tick missing");
endmodule
`default_nettype wire

// ### tmr2_pin_model.sv
// model of the external count and trigger pins
`timescale 1ns/1ps
`default_nettype none
module tmr2_pin_model (
	input wire logic sys_clk,
	output logic countInputPin,
	output logic triggerPin
);
	initial begin
		countInputPin = 1'b1;
		triggerPin = 1'b1;
	end
	// four clocks low and high so the two-flop sync never misses an edge
	task automatic pulse(input logic trig, input int n);
		repeat (n) begin
			@(posedge sys_clk);
			if (trig) triggerPin <= 1'b0;
			else countInputPin <= 1'b0;
			repeat (4) @(posedge sys_clk);
			triggerPin <= 1'b1;
			countInputPin <= 1'b1;
			repeat (4) @(posedge sys_clk);
		end
	endtask
endmodule
`default_nettype wire

// ### tmr2_pkg.sv
// types for the timer-two control logic
package tmr2_pkg;
	typedef struct packed {
		logic overflowFlag;
		logic externalEventFlag;
		logic receiveClockSelect;
		logic transmitClockSelect;
		logic externalTriggerEnable;
		logic runControl;
		logic counterTimerSelect;
		logic captureReloadSelect;
	} tmr2_ctrl_t;
	typedef enum logic [1:0] {TMR2_CAPTURE, TMR2_RELOAD, TMR2_BAUD} tmr2_mode_t;
	typedef struct packed {
		logic receiveBaudTick;
		logic transmitBaudTick;
	} tmr2_baud_t;
endpackage
